// ===== pkg/step_seq_pkg.sv
// Constants and types for the stepped-sine sequencer
package step_seq_pkg;
    // ------------------------------------------------------------
    // Sequence geometry
    // ------------------------------------------------------------
    localparam int unsigned STEP_COUNT = 10;
    localparam logic [3:0] STEP_FIRST = 4'h0;
    localparam logic [3:0] STEP_LAST = 4'h9;
    localparam int unsigned SEL_COUNT = 6;
    localparam logic [5:0] SEL_RESET = 6'h00;
    // ------------------------------------------------------------
    // Clock and step clock range
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned STEP_CLK_MIN_HZ = 100;
    localparam int unsigned STEP_CLK_MAX_HZ = 4000;
    // ------------------------------------------------------------
    // Level codes: sign and magnitude index (0.42, 1.16, 1.397)
    // ------------------------------------------------------------
    localparam logic [1:0] MAG_LOW = 2'h1;
    localparam logic [1:0] MAG_MID = 2'h2;
    localparam logic [1:0] MAG_PEAK = 2'h3;
endpackage

// ===== core/step_sequencer.sv
// Ten-step stepped-sine switch sequencer
// Contract
// - Step counter advances 0..9 ascending on each rising step clock edge, then wraps.
// - Hold input high clears the counter to step 0 and keeps it there; low lets it run.
// - Carry output pulses once per ten-step cycle.
// - Select outputs are registered on the same step clock as the counter.
// - Decode is rotated one step to cancel the output register delay.
// - Steps select +0.42,+1.16,+1.397,+1.16,+0.42 then the negatives.
// - Exactly one of six selects active from the first step on (none after reset); order 1,4,5,4,1,2,0,3,0,2.
// - Switching timed from the step clock to align zero crossings.
module step_sequencer
    import step_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic step_clk,
    input wire logic seq_hold,
    output logic [5:0] sel,
    output logic [1:0] level_mag,
    output logic level_neg,
    output logic carry,
    output logic step_tick
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [1:0] hold_sync;
        logic [3:0] cnt;
        logic [5:0] sel;
        logic [1:0] mag;
        logic neg;
        logic carry;
        logic tick;
    } state_t;

    state_t s_q;
    state_t s_d;

    // One-hot select for a counter value, already rotated by one step
    function automatic logic [5:0] sel_decode(input logic [3:0] c);
        logic [3:0] nxt;
        nxt = (c == STEP_LAST) ? STEP_FIRST : c + 4'h1;
        case (nxt)
            4'h0, 4'h4: sel_decode = 6'h02;
            4'h1, 4'h3: sel_decode = 6'h10;
            4'h2: sel_decode = 6'h20;
            4'h5, 4'h9: sel_decode = 6'h04;
            4'h6, 4'h8: sel_decode = 6'h01;
            4'h7: sel_decode = 6'h08;
            default: sel_decode = SEL_RESET;
        endcase
    endfunction

    // Level for a counter value, rotated alike
    function automatic logic [2:0] lvl_decode(input logic [3:0] c);
        logic [3:0] nxt;
        nxt = (c == STEP_LAST) ? STEP_FIRST : c + 4'h1;
        case (nxt)
            4'h0, 4'h4: lvl_decode = {1'b0, MAG_LOW};
            4'h1, 4'h3: lvl_decode = {1'b0, MAG_MID};
            4'h2: lvl_decode = {1'b0, MAG_PEAK};
            4'h5, 4'h9: lvl_decode = {1'b1, MAG_LOW};
            4'h6, 4'h8: lvl_decode = {1'b1, MAG_MID};
            4'h7: lvl_decode = {1'b1, MAG_PEAK};
            default: lvl_decode = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic edge_seen;
    logic [2:0] lv;

    always_comb begin
        s_d = s_q;
        lv = lvl_decode(s_q.cnt);
        s_d.sclk_sync = {s_q.sclk_sync[1:0], step_clk};
        s_d.hold_sync = {s_q.hold_sync[0], seq_hold};
        edge_seen = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
        s_d.carry = 1'b0;
        s_d.tick = 1'b0;
        if (s_q.hold_sync[1]) begin
            s_d.cnt = STEP_FIRST;
        end else if (edge_seen) begin
            s_d.tick = 1'b1;
            // Output register takes the decode of the old count
            s_d.sel = sel_decode(s_q.cnt);
            s_d.mag = lv[1:0];
            s_d.neg = lv[2];
            if (s_q.cnt == STEP_LAST) begin
                s_d.cnt = STEP_FIRST;
                s_d.carry = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sel = s_q.sel;
    assign level_mag = s_q.mag;
    assign level_neg = s_q.neg;
    assign carry = s_q.carry;
    assign step_tick = s_q.tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_wrap;
        @(posedge clk) disable iff (rst)
        (edge_seen && !s_q.hold_sync[1] && s_q.cnt == STEP_LAST) |=> s_q.cnt == STEP_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_adv;
        @(posedge clk) disable iff (rst)
        (edge_seen && !s_q.hold_sync[1] && s_q.cnt < STEP_LAST)
            |=> s_q.cnt == $past(s_q.cnt) + 4'h1;
    endproperty
    a_adv: assert property (p_adv) else $error("counter did not advance");

    property p_hold;
        @(posedge clk) disable iff (rst)
        s_q.hold_sync[1] |=> s_q.cnt == STEP_FIRST && $stable(sel);
    endproperty
    a_hold: assert property (p_hold) else $error("hold did not stop counter");

    property p_carry;
        @(posedge clk) disable iff (rst)
        carry |-> $past(s_q.cnt) == STEP_LAST && s_q.cnt == STEP_FIRST;
    endproperty
    a_carry: assert property (p_carry) else $error("carry at wrong step");

    property p_onehot;
        @(posedge clk) disable iff (rst)
        step_tick |-> $onehot(sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("select not one-hot");

    property p_rot;
        @(posedge clk) disable iff (rst)
        (step_tick && s_q.cnt == 4'h3) |-> sel == 6'h10 && level_mag == MAG_MID && !level_neg;
    endproperty
    a_rot: assert property (p_rot) else $error("rotated decode wrong");

    property p_peak;
        @(posedge clk) disable iff (rst)
        (step_tick && s_q.cnt == 4'h7) |-> sel == 6'h08 && level_mag == MAG_PEAK && level_neg;
    endproperty
    a_peak: assert property (p_peak) else $error("negative peak wrong");

    property p_reg;
        @(posedge clk) disable iff (rst)
        !step_tick |-> $stable(sel);
    endproperty
    a_reg: assert property (p_reg) else $error("select changed off edge");

    property p_carry_due;
        @(posedge clk) disable iff (rst)
        (edge_seen && !s_q.hold_sync[1] && s_q.cnt == STEP_LAST) |=> carry;
    endproperty
    a_carry_due: assert property (p_carry_due) else $error("carry missing on wrap");

    property p_carry_tick;
        @(posedge clk) disable iff (rst)
        carry |-> step_tick;
    endproperty
    a_carry_tick: assert property (p_carry_tick) else $error("carry without step");

    property p_tick_due;
        @(posedge clk) disable iff (rst)
        (edge_seen && !s_q.hold_sync[1]) |=> step_tick;
    endproperty
    a_tick_due: assert property (p_tick_due) else $error("step edge not taken");

    property p_hold_quiet;
        @(posedge clk) disable iff (rst)
        s_q.hold_sync[1] |=> !step_tick && !carry;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet) else $error("step taken during hold");

    property p_range;
        @(posedge clk) disable iff (rst)
        s_q.cnt <= STEP_LAST;
    endproperty
    a_range: assert property (p_range) else $error("counter out of range");

    property p_step0;
        @(posedge clk) disable iff (rst)
        (step_tick && s_q.cnt == 4'h0) |-> sel == 6'h02 && level_mag == MAG_LOW && !level_neg;
    endproperty
    a_step0: assert property (p_step0) else $error("first step wrong");

    property p_step2;
        @(posedge clk) disable iff (rst)
        (step_tick && s_q.cnt == 4'h2) |-> sel == 6'h20 && level_mag == MAG_PEAK && !level_neg;
    endproperty
    a_step2: assert property (p_step2) else $error("positive peak wrong");

    property p_step5;
        @(posedge clk) disable iff (rst)
        (step_tick && s_q.cnt == 4'h5) |-> sel == 6'h04 && level_mag == MAG_LOW && level_neg;
    endproperty
    a_step5: assert property (p_step5) else $error("first negative step wrong");

    property p_step6;
        @(posedge clk) disable iff (rst)
        (step_tick && s_q.cnt == 4'h6) |-> sel == 6'h01 && level_mag == MAG_MID && level_neg;
    endproperty
    a_step6: assert property (p_step6) else $error("negative mid step wrong");
endmodule

// ===== sim/step_source.sv
// Step clock source model for the sequencer
module step_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] half,
    output logic step_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // Free-running step clock, each phase at least five clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            step_clk <= 1'b0;
        end else if (cnt_q >= half - 4'h1) begin
            cnt_q <= 4'h0;
            step_clk <= ~step_clk;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the stepped-sine sequencer
module testbench import step_seq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, step_clk, seq_hold, level_neg, carry, step_tick, hold_now;
    logic [5:0] sel;
    logic [1:0] level_mag;
    logic [3:0] half;
    logic [2:0] sel_idx [10] = '{3'h1, 3'h4, 3'h5, 3'h4, 3'h1, 3'h2, 3'h0, 3'h3, 3'h0, 3'h2};
    logic [5:0] sel_exp = 6'h00;
    logic [1:0] mag_exp = 2'h0;
    logic neg_exp = 1'b0;
    integer seed = 32'h60165628;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int pos = 0;
    step_source partner (.clk(clk), .rst(rst), .half(half), .step_clk(step_clk));
    step_sequencer DUT (.clk(clk), .rst(rst), .step_clk(step_clk), .seq_hold(seq_hold),
        .sel(sel), .level_mag(level_mag), .level_neg(level_neg), .carry(carry),
        .step_tick(step_tick));
    function automatic logic [1:0] exp_mag(int s);
        return (s % 5 == 2) ? 2'h3 : (s % 5 == 1 || s % 5 == 3) ? 2'h2 : 2'h1;
    endfunction
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        seq_hold = 1'b0;
        half = 4'h5;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge step_clk);
            hold_now = seq_hold;
            repeat (3) @(posedge clk);
            #1;
            if (!hold_now && step_tick !== 1'b1) begin
                @(posedge clk);
                #1;
            end
            pos = hold_now ? 0 : (pos + 1) % STEP_COUNT;
            if (!hold_now) begin
                sel_exp = 6'h01 << sel_idx[pos];
                mag_exp = exp_mag(pos);
                neg_exp = (pos >= 5);
            end
            check("tick", {7'h0, step_tick}, {7'h0, !hold_now});
            check("carry", {7'h0, carry}, {7'h0, !hold_now && pos == 0});
            check("sel", {2'h0, sel}, {2'h0, sel_exp});
            check("level", {5'h0, level_neg, level_mag}, {5'h0, neg_exp, mag_exp});
            @(posedge clk);
            seq_hold <= (i > 30) && ($random(seed) % 5 == 0);
            half <= 4'h5 + 4'($unsigned($random(seed)) % 8);
        end
        stop_test();
    end
endmodule
